/* File: hdl/fo_gpio.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fo_gpio_defines.svh"
module fo_gpio
    import fo_gpio_pkg::*;
#(
    parameter int BLANK_CYCLES  = `BLANK_CYC,
    parameter int FILTER_CYCLES = `FILT_CYC
)(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // chip context
    input  wire logic [2:0]  chip_mode_i,
    input  wire logic        cfg_late_wd_i,
    input  wire logic        watchdog_fault_flag_event_i,
    input  wire logic        wd_trigger_ok_i,
    input  wire logic        wd_off_in_stop_i,
    input  wire logic        thermal_shutdown_stage_two_i,
    input  wire logic        main_regulator_short_i,
    input  wire logic        main_regulator_overvoltage_i,
    input  wire logic [7:0]  pwm_duty_i,
    input  wire logic [7:0]  pwm_frequency_select_i,
    input  wire logic        overcurrent_i,
    // pad
    input  wire logic        pad_i,
    output logic             pad_o,
    output logic             pad_oe_n_o,
    output logic             high_side_on_o,
    output logic             pull_up_en_o,
    output logic             pull_down_en_o,
    output logic             failsafe_request_o,
    output logic             wake_request_o,
    output logic             main_regulator_enable_o,
    output logic             wake_irq_pulse_o
);
    typedef struct packed {
        logic [2:0]  func;
        logic        lock;
        logic        test_drive;
        logic        ovr_en;
        logic [1:0]  pull;
        logic        failure_flag;
        logic        watchdog_fault_flag;
        logic        fail_by_fault;
        logic        wd_seen_once;
        logic        pin_overcurrent_flag;
        logic        pin_wake_event_flag;
        logic        level_stat;
        logic        prev_failsafe;
        logic        prev_restart;
        logic        prev_sleep;
        logic        wake_req;
        logic        irq;
        logic        ack;
        logic [31:0] rdata;
        logic [1:0]  pad_sync;
    } top_state_t;

    top_state_t s_reg;
    top_state_t s_next;

    wake_if wk ();
    logic pwm_on;

    wake_filter #(
        .BLANK_CYCLES  (BLANK_CYCLES),
        .FILTER_CYCLES (FILTER_CYCLES)
    ) u_wake (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pin_i (pad_i),
        .wk    (wk)
    );

    pwm_gen #(
        .WIDTH (8)
    ) u_pwm (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .duty_i     (pwm_duty_i),
        .freq_div_i (pwm_frequency_select_i),
        .on_o       (pwm_on)
    );

    logic       is_fail_cfg;
    logic       is_wake_cfg;
    logic       is_switch_cfg;
    logic       in_normal;
    logic       in_awake;
    logic       fault_now;
    logic       wd_trip;
    logic       fail_drive;
    logic       switch_on;
    logic       wr_stb;
    logic       rd_stb;
    logic [2:0] func_code;

    // function decode and fault collection
    always_comb
    begin
        func_code     = s_reg.func;
        is_fail_cfg   = (func_code <= `FUNC_FAIL_MAX);
        is_wake_cfg   = (func_code == `FUNC_WAKE);
        is_switch_cfg = (func_code == `FUNC_LOW_SIDE) ||
                        (func_code == `FUNC_HIGH_SIDE);
        in_normal     = (chip_mode_i == 3'(MODE_NORMAL));
        in_awake      = in_normal || (chip_mode_i == 3'(MODE_STOP)) ||
                        (chip_mode_i == 3'(MODE_INIT)) ||
                        (chip_mode_i == 3'(MODE_RESTART));
        // overvoltage counts only when its reset enable is set
        fault_now     = thermal_shutdown_stage_two_i || main_regulator_short_i ||
                        (main_regulator_overvoltage_i && s_reg.ovr_en);
        // late configurations let the first watchdog fault pass
        wd_trip       = watchdog_fault_flag_event_i &&
                        (!cfg_late_wd_i || s_reg.wd_seen_once);
        fail_drive    = is_fail_cfg &&
                        (s_reg.fail_by_fault || s_reg.test_drive);
        switch_on     = is_switch_cfg && pwm_on && !s_reg.pin_overcurrent_flag;
        wr_stb        = wb_cyc_i && wb_stb_i && wb_we_i && !s_reg.ack;
        rd_stb        = wb_cyc_i && wb_stb_i && !wb_we_i && !s_reg.ack;
    end

    // all register and fault state
    always_comb
    begin
        s_next = s_reg;
        s_next.pad_sync = {s_reg.pad_sync[0], pad_i};
        s_next.prev_failsafe = (chip_mode_i == 3'(MODE_FAILSAFE));
        s_next.prev_restart  = (chip_mode_i == 3'(MODE_RESTART));
        s_next.prev_sleep    = (chip_mode_i == 3'(MODE_SLEEP));
        s_next.irq = 1'b0;
        s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;

        // bus writes first so hardware sets below win over clears
        if (wr_stb && wb_sel_i[0])
        begin
            if (wb_adr_i == `ADDR_CTRL)
            begin
                s_next.test_drive = wb_dat_i[`CTRL_TEST_BIT];
                s_next.ovr_en = wb_dat_i[`CTRL_OVR_BIT];
                s_next.pull = wb_dat_i[`CTRL_PULL_LSB +: 2];
                s_next.lock = wb_dat_i[`CTRL_LOCK_BIT];
                if (!s_reg.lock && in_normal)
                    s_next.func = wb_dat_i[`CTRL_FUNC_LSB +: 3];
            end
            if (wb_adr_i == `ADDR_DEVICE_STATUS_REGISTER)
            begin
                if (wb_dat_i[`DEV_FAIL_BIT])
                    s_next.failure_flag = 1'b0;
                if (wb_dat_i[`DEV_OC_BIT])
                    s_next.pin_overcurrent_flag = 1'b0;
            end
            if (wb_adr_i == `ADDR_WAKE_STAT && wb_dat_i[`WAKE_EVT_BIT])
                s_next.pin_wake_event_flag = 1'b0;
        end

        // watchdog bookkeeping
        if (watchdog_fault_flag_event_i)
            s_next.wd_seen_once = 1'b1;
        if (wd_trigger_ok_i)
        begin
            s_next.watchdog_fault_flag = 1'b0;
            s_next.wd_seen_once = 1'b0;
        end
        if ((chip_mode_i == 3'(MODE_SLEEP) && !s_reg.prev_sleep) ||
            (chip_mode_i == 3'(MODE_FAILSAFE) && !s_reg.prev_failsafe &&
             fault_now) ||
            (chip_mode_i == 3'(MODE_STOP) && wd_off_in_stop_i))
            s_next.watchdog_fault_flag = 1'b0;

        // fault latch: sets every cycle the cause is present
        if (is_fail_cfg && (fault_now || wd_trip))
        begin
            s_next.fail_by_fault = 1'b1;
            s_next.failure_flag = 1'b1;
        end
        else if (!is_fail_cfg && (fault_now || wd_trip))
            s_next.failure_flag = 1'b1;
        if (wd_trip)
            s_next.watchdog_fault_flag = 1'b1;
        // release only from normal with every cause gone
        if (in_normal && s_reg.fail_by_fault && !fault_now && !wd_trip &&
            !s_next.failure_flag && !s_next.watchdog_fault_flag)
            s_next.fail_by_fault = 1'b0;

        // restart entry drops a test-only drive
        if (chip_mode_i == 3'(MODE_RESTART) && !s_reg.prev_restart)
            s_next.test_drive = 1'b0;

        // overcurrent only judged while the switch is on
        if (is_switch_cfg && pwm_on && overcurrent_i)
        begin
            s_next.pin_overcurrent_flag = 1'b1;
            s_next.func = `FUNC_OFF;
        end
        if (is_switch_cfg && ((chip_mode_i == 3'(MODE_RESTART)) ||
                              (chip_mode_i == 3'(MODE_FAILSAFE))))
            s_next.func = `FUNC_OFF;

        // wake handling
        s_next.wake_req = 1'b0;
        if (is_wake_cfg && wk.edge_pulse)
        begin
            s_next.pin_wake_event_flag = 1'b1;
            if (chip_mode_i == 3'(MODE_NORMAL) || chip_mode_i == 3'(MODE_STOP))
                s_next.irq = 1'b1;
            if (chip_mode_i == 3'(MODE_SLEEP))
                s_next.wake_req = 1'b1;
        end
        if (chip_mode_i == 3'(MODE_FAILSAFE) && !s_reg.prev_failsafe)
            s_next.pin_wake_event_flag = 1'b0;

        // level tracked in all modes, shown only while awake
        if (is_wake_cfg)
            s_next.level_stat = wk.level;
        else if (is_switch_cfg)
            s_next.level_stat = s_reg.pad_sync[1];
        else
            s_next.level_stat = 1'b0;

        // read data registered with the ack
        s_next.rdata = 32'h0000_0000;
        if (rd_stb)
        begin
            unique case (wb_adr_i)
                `ADDR_CTRL:
                    s_next.rdata = {24'h00_0000, s_reg.pull, s_reg.ovr_en,
                                    s_reg.test_drive, s_reg.lock, s_reg.func};
                `ADDR_DEVICE_STATUS_REGISTER:
                    s_next.rdata = {29'h0, s_reg.pin_overcurrent_flag,
                                    s_reg.watchdog_fault_flag,
                                    s_reg.failure_flag};
                `ADDR_WAKE_STAT:
                    s_next.rdata = {31'h0, s_reg.pin_wake_event_flag};
                `ADDR_LVL_STAT:
                    s_next.rdata = {31'h0, s_reg.level_stat && in_awake};
                default:
                    s_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign wk.enable = is_wake_cfg;

    // open drain: low drive when failing or low-side on
    assign pad_o      = 1'b0;
    assign pad_oe_n_o = !(fail_drive ||
                          (switch_on && func_code == `FUNC_LOW_SIDE));
    assign high_side_on_o = switch_on && (func_code == `FUNC_HIGH_SIDE);
    assign pull_up_en_o   = is_wake_cfg && s_reg.pull[0];
    assign pull_down_en_o = is_wake_cfg && s_reg.pull[1];
    // late configs keep any failure out of fail-safe in normal while the watchdog flag is set
    assign failsafe_request_o = s_reg.fail_by_fault &&
                                (!in_normal || !cfg_late_wd_i ||
                                 !s_reg.watchdog_fault_flag);
    assign wake_request_o = s_reg.wake_req;
    assign main_regulator_enable_o = !(chip_mode_i == 3'(MODE_SLEEP)) ||
                                     s_reg.wake_req;
    assign wake_irq_pulse_o = s_reg.irq;
    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.rdata;
endmodule
`default_nettype wire

/* File: hdl/fo_gpio_defines.svh */
`ifndef FO_GPIO_DEFINES_SVH
`define FO_GPIO_DEFINES_SVH

// register byte offsets (wishbone, one word each)
`define ADDR_CTRL        4'h0
`define ADDR_DEVICE_STATUS_REGISTER    4'h4
`define ADDR_WAKE_STAT   4'h8
`define ADDR_LVL_STAT    4'hc
// control register fields
`define CTRL_FUNC_LSB    0
`define CTRL_LOCK_BIT    3
`define CTRL_TEST_BIT    4
`define CTRL_OVR_BIT     5
`define CTRL_PULL_LSB    6
// device status fields (write one to clear the fail and overcurrent flags only)
`define DEV_FAIL_BIT     0
`define DEV_WDF_BIT      1
`define DEV_OC_BIT       2
// wake status field
`define WAKE_EVT_BIT     0
// function codes
`define FUNC_FAIL_MAX    3'h2
`define FUNC_OFF         3'h4
`define FUNC_WAKE        3'h5
`define FUNC_LOW_SIDE    3'h6
`define FUNC_HIGH_SIDE   3'h7
// reset values
`define CTRL_RESET       8'h00
// timing at 10 MHz
`define CLK_HZ           10000000
`define BLANK_US         20
`define BLANK_CYC        ((`BLANK_US * `CLK_HZ + 999999) / 1000000)
`define FILT_US          16
`define FILT_CYC         ((`FILT_US * `CLK_HZ + 999999) / 1000000)

`endif

/* File: hdl/fo_gpio_pkg.sv */
package fo_gpio_pkg;

    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_INIT,
        MODE_RESTART,
        MODE_FAILSAFE
    } chip_mode_t;

    typedef enum logic [1:0] {
        WK_IDLE,
        WK_BLANK,
        WK_LIVE
    } wake_state_t;

endpackage

/* File: hdl/wake_if.sv */
`timescale 1ns/1ps
`default_nettype none
// wake qualifier control and results
interface wake_if;
    logic enable;
    logic level;
    logic edge_pulse;
    logic live;

    modport owner (output enable, input level, input edge_pulse, input live);
    modport filter (input enable, output level, output edge_pulse,
                    output live);
endinterface
`default_nettype wire

/* File: hdl/wake_filter.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fo_gpio_defines.svh"
module wake_filter
    import fo_gpio_pkg::*;
#(
    parameter int BLANK_CYCLES  = `BLANK_CYC,
    parameter int FILTER_CYCLES = `FILT_CYC
)(
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    input  wire logic   pin_i,
    wake_if.filter      wk
);
    typedef struct packed {
        wake_state_t state;
        logic [1:0]  sync;
        logic [15:0] count;
        logic        level;
        logic        edge_pulse;
    } wf_state_t;

    wf_state_t s_reg;
    wf_state_t s_next;

    // blank after configure, then filter every level change
    always_comb
    begin
        s_next = s_reg;
        s_next.sync = {s_reg.sync[0], pin_i};
        s_next.edge_pulse = 1'b0;
        if (!wk.enable)
        begin
            s_next.state = WK_IDLE;
            s_next.count = 16'h0000;
        end
        else
        begin
            unique case (s_reg.state)
                WK_IDLE:
                begin
                    s_next.state = WK_BLANK;
                    s_next.count = 16'h0000;
                end
                WK_BLANK:
                begin
                    s_next.count = s_reg.count + 16'h0001;
                    if (s_reg.count >= 16'(BLANK_CYCLES - 1))
                    begin
                        s_next.state = WK_LIVE;
                        s_next.count = 16'h0000;
                    end
                end
                WK_LIVE:
                begin
                    // stored reference is the last filtered level
                    if (s_reg.sync[1] == s_reg.level)
                        s_next.count = 16'h0000;
                    else if (s_reg.count >= 16'(FILTER_CYCLES - 1))
                    begin
                        s_next.level = s_reg.sync[1];
                        s_next.edge_pulse = 1'b1;
                        s_next.count = 16'h0000;
                    end
                    else
                        s_next.count = s_reg.count + 16'h0001;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign wk.level      = s_reg.level;
    assign wk.edge_pulse = s_reg.edge_pulse;
    assign wk.live       = (s_reg.state == WK_LIVE);
endmodule
`default_nettype wire

/* File: hdl/pwm_gen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fo_gpio_defines.svh"
module pwm_gen #(
    parameter int WIDTH = 8
)(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] duty_i,
    input  wire logic [7:0]       freq_div_i,
    output logic                  on_o
);
    typedef struct packed {
        logic [7:0]       pre;
        logic [WIDTH-1:0] phase;
        logic             on;
    } pwm_state_t;

    pwm_state_t s_reg;
    pwm_state_t s_next;

    // prescaled phase counter; all-ones duty means permanently on
    always_comb
    begin
        s_next = s_reg;
        if (s_reg.pre >= freq_div_i)
        begin
            s_next.pre = 8'h00;
            s_next.phase = s_reg.phase + 1'b1;
        end
        else
            s_next.pre = s_reg.pre + 8'h01;
        s_next.on = (duty_i == '1) || (s_next.phase < duty_i);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign on_o = s_reg.on;
endmodule
`default_nettype wire

/* File: verif/fo_gpio_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module fo_gpio_assertions
    import fo_gpio_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic [2:0] chip_mode_i,
    input wire logic       thermal_shutdown_stage_two_i,
    input wire logic       overcurrent_i,
    input wire logic       pad_oe_n_o,
    input wire logic       high_side_on_o,
    input wire logic       pull_up_en_o,
    input wire logic       pull_down_en_o,
    input wire logic       failsafe_request_o,
    input wire logic       wake_request_o,
    input wire logic       main_regulator_enable_o,
    input wire logic       wake_irq_pulse_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a request the slave has not yet answered
    sequence wb_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // switch released and kept released
    sequence pin_freed;
        pad_oe_n_o ##1 pad_oe_n_o;
    endsequence
    AST_ACK_NEXT: assert property (wb_req |=> wb_ack_o)
        else $error("ack not one cycle after request");
    AST_ACK_DROP: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_IRQ_MODE: assert property (wake_irq_pulse_o |->
        $past(chip_mode_i) inside {MODE_NORMAL, MODE_STOP})
        else $error("wake interrupt outside normal or stop");
    AST_WAKE_SLEEP: assert property (wake_request_o |->
        $past(chip_mode_i) == MODE_SLEEP)
        else $error("chip wake outside sleep");
    AST_REG_ON: assert property (wake_request_o |->
        ##[0:2] main_regulator_enable_o)
        else $error("regulator not enabled on wake");
    AST_TSD_FAIL: assert property ($rose(thermal_shutdown_stage_two_i)
        |-> ##[1:3] failsafe_request_o)
        else $error("thermal fault without fail-safe request");
    AST_FAIL_HOLD: assert property (failsafe_request_o && !pad_oe_n_o
        && chip_mode_i == MODE_STOP |=> !pad_oe_n_o)
        else $error("fail drive dropped in stop");
    AST_OC_OFF: assert property (overcurrent_i && !pad_oe_n_o
        && !failsafe_request_o |-> ##[1:4] pin_freed)
        else $error("switch not shut down on overcurrent");
    AST_PULL_EXCL: assert property (!(pull_up_en_o && pull_down_en_o))
        else $error("pull-up and pull-down both on");
    AST_SIDE_EXCL: assert property (!(high_side_on_o && !pad_oe_n_o))
        else $error("high side and low drive together");
endmodule
`default_nettype wire

/* File: verif/pin_load.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_load (
    input  wire logic pad_oe_n_i,
    input  wire logic high_side_i,
    input  wire logic pull_down_i,
    input  wire logic drive_en_i,
    input  wire logic drive_val_i,
    output logic      pin_o
);
    // open-drain low wins; a board pull-up keeps a released pin high unless an external drive or the pull-down sets it
    always_comb
    begin
        if (!pad_oe_n_i)
            pin_o = 1'b0;
        else if (high_side_i)
            pin_o = 1'b1;
        else if (drive_en_i)
            pin_o = drive_val_i;
        else if (pull_down_i)
            pin_o = 1'b0;
        else
            pin_o = 1'b1;
    end
endmodule
`default_nettype wire

/* File: verif/tb_fo_gpio.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_fo_gpio;
    import fo_gpio_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] dw = 32'h0, rd, dat;
    logic [2:0]  mode = MODE_NORMAL;
    logic [2:0]  cause = 3'h0;
    logic        late = 0, wdf = 0, wdok = 0, oc = 0, ex_en = 0, ex_v = 0;
    logic [7:0]  duty = 8'h00;
    logic        pad, oen, hs, pu, pd, fsr, wreq, reg_en, irq, ack;
    int          errors = 0, tests_run = 0, irq_n = 0, wreq_n = 0, c;
    int          reg_n = 0;
    logic        wdoff = 1'b0;

    always #50 clk_i = ~clk_i;
    // count one-cycle pulses so tests need not catch the exact edge
    always @(posedge clk_i)
    begin
        irq_n <= irq_n + (irq === 1'b1);
        wreq_n <= wreq_n + (wreq === 1'b1);
        reg_n <= reg_n + (mode == MODE_SLEEP && reg_en === 1'b1);
    end

    fo_gpio #(.BLANK_CYCLES(4), .FILTER_CYCLES(4)) DUT (.clk_i, .rst_i,
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(dw), .wb_dat_o(dat), .wb_ack_o(ack),
        .chip_mode_i(mode), .cfg_late_wd_i(late), .watchdog_fault_flag_event_i(wdf),
        .wd_trigger_ok_i(wdok), .wd_off_in_stop_i(wdoff),
        .thermal_shutdown_stage_two_i(cause[0]),
        .main_regulator_short_i(cause[1]),
        .main_regulator_overvoltage_i(cause[2]), .pwm_duty_i(duty),
        .pwm_frequency_select_i(8'h01), .overcurrent_i(oc), .pad_i(pad),
        .pad_o(), .pad_oe_n_o(oen), .high_side_on_o(hs), .pull_up_en_o(pu),
        .pull_down_en_o(pd), .failsafe_request_o(fsr),
        .wake_request_o(wreq), .main_regulator_enable_o(reg_en),
        .wake_irq_pulse_o(irq));
    pin_load u_load (.pad_oe_n_i(oen), .high_side_i(hs), .pull_down_i(pd),
        .drive_en_i(ex_en), .drive_val_i(ex_v), .pin_o(pad));

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // classic cycle: hold until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        do @(posedge clk_i); while (ack !== 1'b1 && ++n < 50);
        rd = dat;
        chk("ack", 1, ack);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic t_reset;
        wb(0, 4'h0, 0);
        chk("ctrl", 0, rd);
        chk("idle pin", 1, oen);
        wb(1, 4'h2, 32'hff);
        wb(0, 4'h2, 0);
        chk("unmapped", 0, rd);
        $display("reset test done");
    endtask

    task automatic t_cause(input int k, input logic ovr, input logic f);
        wb(1, 4'h0, {26'h0, ovr, 5'h0});
        @(posedge clk_i) cause[k] <= 1'b1;
        tick(3);
        @(negedge clk_i) chk("fail pin", !f, oen);
        chk("fail-safe", f, fsr);
        @(posedge clk_i) cause[k] <= 1'b0;
        mode <= MODE_STOP;
        tick(3);
        @(negedge clk_i) chk("held", !f, oen);
        @(posedge clk_i) mode <= MODE_NORMAL;
        wb(0, 4'h4, 0);
        chk("failure flag", f, rd[0]);
        wb(1, 4'h4, 32'h1);
        @(negedge clk_i) chk("released", 1, oen);
        $display("cause test done");
    endtask

    task automatic pulse(input logic ok);
        @(posedge clk_i) {wdok, wdf} <= {ok, !ok};
        @(posedge clk_i) {wdok, wdf} <= 2'b00;
        tick(2);
    endtask

    task automatic t_wd(input logic lt);
        @(posedge clk_i) late <= lt;
        pulse(0);
        @(negedge clk_i) chk("first fault", lt, oen);
        if (lt)
            pulse(0);
        @(negedge clk_i) chk("second fault", 0, oen);
        wb(1, 4'h4, 32'h1);
        @(negedge clk_i) chk("needs trigger", 0, oen);
        // late run clears the flag by switching the watchdog off in stop
        if (lt)
        begin
            @(posedge clk_i) {mode, wdoff} <= {MODE_STOP, 1'b1};
            @(posedge clk_i) {mode, wdoff} <= {MODE_NORMAL, 1'b0};
        end
        else
            pulse(1);
        wb(0, 4'h4, 0);
        chk("wd flag", 0, rd[1]);
        wb(1, 4'h4, 32'h1);
        @(negedge clk_i) chk("wd released", 1, oen);
        $display("watchdog test done");
    endtask

    task automatic t_test;
        wb(1, 4'h0, 32'h10);
        @(negedge clk_i) chk("test on", 0, oen);
        wb(1, 4'h0, 32'h14);
        @(negedge clk_i) chk("test off cfg", 1, oen);
        wb(1, 4'h0, 32'h10);
        @(posedge clk_i) mode <= MODE_RESTART;
        tick(2);
        @(negedge clk_i) chk("restart", 1, oen);
        @(posedge clk_i) mode <= MODE_NORMAL;
        tick(2);
        @(negedge clk_i) chk("back normal", 1, oen);
        wb(1, 4'h0, 0);
        $display("test drive test done");
    endtask

    task automatic t_lock;
        wb(1, 4'h0, 32'h08);
        wb(1, 4'h0, 32'h0c);
        wb(0, 4'h0, 0);
        chk("locked", 32'h08, rd);
        wb(1, 4'h0, 0);
        wb(1, 4'h0, 32'h04);
        @(posedge clk_i) mode <= MODE_STOP;
        wb(1, 4'h0, 0);
        wb(0, 4'h0, 0);
        chk("stop write", 32'h04, rd);
        @(posedge clk_i) mode <= MODE_NORMAL;
        wb(1, 4'h0, 0);
        $display("lock test done");
    endtask

    task automatic t_wake;
        @(posedge clk_i) {ex_en, ex_v} <= 2'b11;
        wb(1, 4'h0, 32'h45);
        @(negedge clk_i) chk("pull up", 1, pu);
        tick(20);
        wb(0, 4'hc, 0);
        chk("level high", 1, rd);
        wb(1, 4'h8, 32'h1);
        c = irq_n;
        @(posedge clk_i) ex_v <= 1'b0;
        tick(20);
        chk("irq", c + 1, irq_n);
        wb(0, 4'hc, 0);
        chk("level", 0, rd);
        wb(0, 4'h8, 0);
        chk("event", 1, rd[0]);
        wb(1, 4'h8, 32'h1);
        @(posedge clk_i) mode <= MODE_RESTART;
        c = irq_n;
        @(posedge clk_i) ex_v <= 1'b1;
        tick(20);
        chk("no irq", c, irq_n);
        @(posedge clk_i) mode <= MODE_NORMAL;
        wb(0, 4'h8, 0);
        chk("restart event", 1, rd[0]);
        wb(1, 4'h8, 32'h1);
        @(posedge clk_i) mode <= MODE_SLEEP;
        c = wreq_n;
        @(posedge clk_i) ex_v <= 1'b0;
        tick(20);
        chk("chip wake", c + 1, wreq_n);
        chk("regulator", 1, reg_n);
        @(posedge clk_i) mode <= MODE_FAILSAFE;
        tick(2);
        @(posedge clk_i) mode <= MODE_NORMAL;
        wb(0, 4'h8, 0);
        chk("fs clears", 0, rd[0]);
        @(posedge clk_i) ex_en <= 1'b0;
        wb(1, 4'h0, 0);
        $display("wake test done");
    endtask

    task automatic t_switch;
        @(posedge clk_i) duty <= 8'hff;
        wb(1, 4'h0, 32'h06);
        tick(10);
        @(negedge clk_i) chk("ls on", 0, oen);
        wb(0, 4'hc, 0);
        chk("ls level", 0, rd[0]);
        @(posedge clk_i) duty <= 8'h00;
        tick(4);
        @(negedge clk_i) chk("ls off", 1, oen);
        wb(0, 4'hc, 0);
        chk("ls level high", 1, rd[0]);
        @(posedge clk_i) duty <= 8'hff;
        tick(4);
        @(posedge clk_i) oc <= 1'b1;
        tick(6);
        @(negedge clk_i) chk("oc off", 1, oen);
        @(posedge clk_i) oc <= 1'b0;
        wb(0, 4'h4, 0);
        chk("oc flag", 1, rd[2]);
        wb(0, 4'h0, 0);
        chk("forced off", 3'h4, rd[2:0]);
        wb(1, 4'h4, 32'h4);
        wb(1, 4'h0, 32'h07);
        @(negedge clk_i) chk("hs on", 1, hs);
        @(posedge clk_i) mode <= MODE_RESTART;
        @(posedge clk_i) mode <= MODE_NORMAL;
        wb(0, 4'h0, 0);
        chk("restart off", 3'h4, rd[2:0]);
        wb(1, 4'h0, 0);
        $display("switch test done");
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        tick(11);
        @(posedge clk_i) rst_i <= 1'b0;
        t_reset();
        t_cause(0, 0, 1);
        t_cause(1, 0, 1);
        t_cause(2, 0, 0);
        t_cause(2, 1, 1);
        t_wd(0);
        t_wd(1);
        t_test();
        t_lock();
        t_wake();
        t_switch();
        results();
    end

    // the sequence needs well under a thousand cycles
    initial
    begin
        tick(5000);
        errors++;
        results();
    end
endmodule
bind fo_gpio fo_gpio_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .chip_mode_i, .thermal_shutdown_stage_two_i,
    .overcurrent_i, .pad_oe_n_o, .high_side_on_o, .pull_up_en_o,
    .pull_down_en_o, .failsafe_request_o, .wake_request_o,
    .main_regulator_enable_o, .wake_irq_pulse_o);
`default_nettype wire
